// ===== gpdi_defines.svh
// Constants of the GPIB device interface: command codes, addressing, timing.
// Assumes one clock at the rate named below; included by its bare name.
`ifndef GPDI_DEFINES_SVH
`define GPDI_DEFINES_SVH

// Address groups and group mask
`define GPDI_LAG_BASE 7'h20
`define GPDI_TAG_BASE 7'h40
`define GPDI_GRP_MASK 7'h60

// Multiline command codes
`define GPDI_CMD_GTL 7'h01
`define GPDI_CMD_SDC 7'h04
`define GPDI_CMD_GET 7'h08
`define GPDI_CMD_LLO 7'h11
`define GPDI_CMD_DCL 7'h14
`define GPDI_CMD_SPE 7'h18
`define GPDI_CMD_SPD 7'h19
`define GPDI_CMD_UNL 7'h3f
`define GPDI_CMD_UNT 7'h5f

// Timing: longest allowed settle after attention, rounded down
`define GPDI_CLK_NS 4
`define GPDI_ATN_SETTLE_NS 100
`define GPDI_ATN_SETTLE_CYC (`GPDI_ATN_SETTLE_NS / `GPDI_CLK_NS)

// Sampled bus bundle and its released (idle) level
`define GPDI_BUS_W 15
`define GPDI_BUS_IDLE 15'h7fff

// Status byte layout and receive buffer depth
`define GPDI_RSV_BIT 6
`define GPDI_BUF_DEPTH 2

`endif

// ===== gpdi_pkg.sv
// Types of the GPIB device interface: handshake state machine encodings.
// Assumes nothing beyond a SystemVerilog compiler.
package gpdi_pkg;

	// Acceptor handshake states
	typedef enum logic [1:0] {
		ac_idle = 2'b00,
		ac_rdy = 2'b01,
		ac_take = 2'b10,
		ac_wait = 2'b11
	} gpdi_acc_t;

	// Source handshake states
	typedef enum logic [1:0] {
		sr_idle = 2'b00,
		sr_wait = 2'b01,
		sr_dav = 2'b10,
		sr_done = 2'b11
	} gpdi_src_t;

endpackage : gpdi_pkg

// ===== gpdi_sync.sv
// Two-flop synchroniser bank for the clockless bus lines.
// Assumes inputs may change at any time relative to mclk.
module gpdi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] async_d,
	output logic [W-1:0] sync_q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second; reset to released bus level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= async_d;
			sync_q <= meta_q;
		end
	end

endmodule : gpdi_sync

// ===== gpdi_buf.sv
// Small valid/ready buffer between the acceptor and the user receive port.
// Assumes DEPTH of at least two; data sits in flip-flops indexed by pointer.
module gpdi_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	// Honest full and empty
	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_q[rd_q];

	// Storage, no reset needed on data
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	a_buf_fill_stall: assert property (@(posedge mclk) disable iff (!rst_n)
		(push && !pop && cnt_q == FULL - 1'b1) |=> (!in_ready && out_valid))
		else $error("buffer did not stall the source when filled");

endmodule : gpdi_buf

// ===== gpdi_core.sv
// GPIB instrument-side interface: acceptor, source, address and command logic.
// Assumes open-drain bus drivers outside; oe high pulls a line low (true).
// What this block does
// - Every bus line is low true; driven low means true.
// - Whole bytes move one per handshake over eight shared data lines.
// - Bytes taken with attention true are addresses or interface commands.
// - Bytes taken with attention false are device data for the user.
// - Source drives data valid; acceptors drive not-ready and not-accepted.
// - Source waits for not-ready released and not-accepted held.
// - Acceptor lines settle within 100 ns after attention turns true.
// - When conditions hold, source asserts data valid.
// - After data valid, acceptor holds not-ready, then releases not-accepted.
// - Handshake is fully interlocked with no fixed timing.
// - Device drives only service request and end; never attention, clear, remote.
// - Remote enable true moves device to remote; lockout may apply.
// - End marks the last byte sent and is passed up on receive.
// - Interface clear returns talker and listener to idle.
// - Device asserts service request when it needs attention.
// - Local lockout and device clear act without addressing.
// - Serial poll enable and disable enter and leave poll mode.
// - Selective clear while listen-addressed restores defaults.
// - Go-to-local while listen-addressed returns to local mode.
// - Unlisten drops the listener role.
// - Untalk drops the talker role.
// - Listen address is address OR 20h, talk address OR 40h.
// - Command codes are fixed byte values per command.
`include "gpdi_defines.svh"

module gpdi_core #(
	parameter int ADDR_W = 5,
	parameter int BUF_DEPTH = `GPDI_BUF_DEPTH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bus lines in, raw electrical level
	input wire logic [7:0] dio_n_i,
	input wire logic atn_n_i,
	input wire logic ifc_n_i,
	input wire logic ren_n_i,
	input wire logic dav_n_i,
	input wire logic nrfd_n_i,
	input wire logic ndac_n_i,
	input wire logic eoi_n_i,
	// Bus drivers, open drain
	output logic [7:0] dio_o,
	output logic [7:0] dio_oe,
	output logic dav_o,
	output logic dav_oe,
	output logic nrfd_o,
	output logic nrfd_oe,
	output logic ndac_o,
	output logic ndac_oe,
	output logic eoi_o,
	output logic eoi_oe,
	output logic srq_o,
	output logic srq_oe,
	// Configuration and front panel
	input wire logic [ADDR_W-1:0] my_addr,
	input wire logic lock_cfg,
	input wire logic local_key,
	// Received device data
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_end,
	// Device data to send
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_end,
	// Service request and status
	input wire logic svc_req,
	input wire logic [7:0] status_byte,
	output logic remote,
	output logic front_lockout,
	output logic listen_act,
	output logic talk_act,
	output logic spoll_act,
	output logic dev_clear,
	output logic trigger
);

	localparam int ATN_CYC = `GPDI_ATN_SETTLE_CYC;

	////////////////////////////////////////////////////////////////////////////
	// Input sampling

	logic [`GPDI_BUS_W-1:0] bus_s;
	logic [7:0] dio_s;
	logic atn_s, ifc_s, ren_s, dav_s, nrfd_s, ndac_s, eoi_s;
	logic [7:0] dio_t;
	logic atn_t, ifc_t, ren_t, dav_t, nrfd_t, ndac_t, eoi_t;

	// The bus has no clock, so every line is resynchronised
	gpdi_sync #(.W(`GPDI_BUS_W), .RST(`GPDI_BUS_IDLE)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_d({dio_n_i, atn_n_i, ifc_n_i, ren_n_i, dav_n_i, nrfd_n_i, ndac_n_i, eoi_n_i}),
		.sync_q(bus_s)
	);
	assign {dio_s, atn_s, ifc_s, ren_s, dav_s, nrfd_s, ndac_s, eoi_s} = bus_s;

	// Low level means true on every line
	assign dio_t = ~dio_s;
	assign atn_t = ~atn_s;
	assign ifc_t = ~ifc_s;
	assign ren_t = ~ren_s;
	assign dav_t = ~dav_s;
	assign nrfd_t = ~nrfd_s;
	assign ndac_t = ~ndac_s;
	assign eoi_t = ~eoi_s;

	////////////////////////////////////////////////////////////////////////////
	// State

	gpdi_pkg::gpdi_acc_t acc_q;
	gpdi_pkg::gpdi_src_t src_q;
	logic [7:0] cap_byte_q, sh_byte_q, poll_byte;
	logic cap_atn_q, cap_eoi_q, sh_eoi_q;
	logic listen_q, talk_q, spoll_q, remote_q, llo_q, ren_q, clear_q, trig_q;
	logic acc_act, take_now, buf_in_valid, buf_in_ready;
	logic src_act, drive;
	logic [8:0] rx_word;

	// Own-address match, shared by listen and talk decode
	function automatic logic addr_hit(input logic [6:0] cmd, input logic [6:0] base,
		input logic [ADDR_W-1:0] pa);
		addr_hit = (cmd == (base | 7'(pa)));
	endfunction : addr_hit

	////////////////////////////////////////////////////////////////////////////
	// Acceptor handshake

	// Everyone accepts under attention; only a listener accepts data
	assign acc_act = atn_t | listen_q;
	// Data waits for buffer room, so a stalled receiver loses no byte
	assign take_now = (acc_q == gpdi_pkg::ac_rdy) & acc_act & dav_t & (atn_t | buf_in_ready);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= gpdi_pkg::ac_idle;
		end else if (ifc_t) begin
			acc_q <= gpdi_pkg::ac_idle;
		end else begin
			unique case (acc_q)
				gpdi_pkg::ac_idle: begin
					if (acc_act && !dav_t && (atn_t || buf_in_ready)) begin
						acc_q <= gpdi_pkg::ac_rdy;
					end
				end
				gpdi_pkg::ac_rdy: begin
					if (!acc_act) begin
						acc_q <= gpdi_pkg::ac_idle;
					end else if (take_now) begin
						acc_q <= gpdi_pkg::ac_take;
					end
				end
				gpdi_pkg::ac_take: begin
					acc_q <= gpdi_pkg::ac_wait;
				end
				gpdi_pkg::ac_wait: begin
					if (!dav_t) begin
						acc_q <= gpdi_pkg::ac_idle;
					end
				end
			endcase
		end
	end

	// Latch byte, attention and end as data valid is seen
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cap_byte_q <= 8'h00;
			cap_atn_q <= 1'b0;
			cap_eoi_q <= 1'b0;
		end else if (take_now) begin
			cap_byte_q <= dio_t;
			cap_atn_q <= atn_t;
			cap_eoi_q <= eoi_t;
		end
	end

	// Hold not-ready except when ready; hold not-accepted until taken
	assign nrfd_oe = acc_act & (acc_q != gpdi_pkg::ac_rdy);
	assign ndac_oe = acc_act & (acc_q != gpdi_pkg::ac_wait);
	assign nrfd_o = 1'b0;
	assign ndac_o = 1'b0;

	// Data bytes go to the user, never to the decoder
	assign buf_in_valid = (acc_q == gpdi_pkg::ac_take) & ~cap_atn_q;

	gpdi_buf #(.W(9), .DEPTH(BUF_DEPTH)) u_rxbuf (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data({cap_eoi_q, cap_byte_q}),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_word)
	);
	assign {rx_end, rx_data} = rx_word;

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic [6:0] cmd;
	logic cmd_go, is_unl, is_unt, is_mla, is_mta, is_ota, is_addr;
	assign cmd = cap_byte_q[6:0];
	assign cmd_go = (acc_q == gpdi_pkg::ac_take) & cap_atn_q;
	assign is_unl = cmd_go & (cmd == `GPDI_CMD_UNL);
	assign is_unt = cmd_go & (cmd == `GPDI_CMD_UNT);
	assign is_mla = cmd_go & ~is_unl & addr_hit(cmd, `GPDI_LAG_BASE, my_addr);
	assign is_mta = cmd_go & ~is_unt & addr_hit(cmd, `GPDI_TAG_BASE, my_addr);
	assign is_ota = cmd_go & ~is_mta & ((cmd & `GPDI_GRP_MASK) == `GPDI_TAG_BASE);
	// Addressed commands count only while listen-addressed
	assign is_addr = cmd_go & listen_q;

	// Listener and talker roles
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			listen_q <= 1'b0;
			talk_q <= 1'b0;
		end else if (ifc_t) begin
			listen_q <= 1'b0;
			talk_q <= 1'b0;
		end else begin
			if (is_unl || is_mta) begin
				listen_q <= 1'b0;
			end else if (is_mla) begin
				listen_q <= 1'b1;
			end
			if (is_unt || is_ota || is_mla) begin
				talk_q <= 1'b0;
			end else if (is_mta) begin
				talk_q <= 1'b1;
			end
		end
	end

	// Serial poll mode
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			spoll_q <= 1'b0;
		end else if (ifc_t) begin
			spoll_q <= 1'b0;
		end else if (cmd_go && cmd == `GPDI_CMD_SPE) begin
			spoll_q <= 1'b1;
		end else if (cmd_go && cmd == `GPDI_CMD_SPD) begin
			spoll_q <= 1'b0;
		end
	end

	// Remote, local and lockout; entering remote wins over a local key
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ren_q <= 1'b0;
			remote_q <= 1'b0;
			llo_q <= 1'b0;
		end else begin
			ren_q <= ren_t;
			if (!ren_t) begin
				remote_q <= 1'b0;
				llo_q <= 1'b0;
			end else begin
				if (!ren_q || is_mla) begin
					remote_q <= 1'b1;
				end else if ((is_addr && cmd == `GPDI_CMD_GTL) || (local_key && !front_lockout)) begin
					remote_q <= 1'b0;
				end
				if (cmd_go && cmd == `GPDI_CMD_LLO) begin
					llo_q <= 1'b1;
				end
			end
		end
	end
	assign front_lockout = remote_q & (llo_q | lock_cfg);

	// One-cycle clear and trigger pulses to the instrument
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clear_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			clear_q <= (cmd_go && cmd == `GPDI_CMD_DCL) || (is_addr && cmd == `GPDI_CMD_SDC);
			trig_q <= is_addr && cmd == `GPDI_CMD_GET;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Source handshake

	// Talk only while addressed and attention is false
	assign src_act = talk_q & ~atn_t;
	assign tx_ready = (src_q == gpdi_pkg::sr_idle) & src_act & ~spoll_q;

	// Poll answer carries the request flag in its own bit
	always_comb begin
		poll_byte = status_byte;
		poll_byte[`GPDI_RSV_BIT] = svc_req;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= gpdi_pkg::sr_idle;
		end else if (ifc_t || !talk_q) begin
			src_q <= gpdi_pkg::sr_idle;
		end else begin
			unique case (src_q)
				gpdi_pkg::sr_idle: begin
					if (src_act && (spoll_q || tx_valid)) begin
						src_q <= gpdi_pkg::sr_wait;
					end
				end
				gpdi_pkg::sr_wait: begin
					if (src_act && !nrfd_t && ndac_t) begin
						src_q <= gpdi_pkg::sr_dav;
					end
				end
				gpdi_pkg::sr_dav: begin
					if (!ndac_t) begin
						src_q <= gpdi_pkg::sr_done;
					end
				end
				gpdi_pkg::sr_done: begin
					src_q <= gpdi_pkg::sr_idle;
				end
			endcase
		end
	end

	// Outgoing byte held from load until accepted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sh_byte_q <= 8'h00;
			sh_eoi_q <= 1'b0;
		end else if (src_q == gpdi_pkg::sr_idle && src_act && (spoll_q || tx_valid)) begin
			sh_byte_q <= spoll_q ? poll_byte : tx_data;
			sh_eoi_q <= ~spoll_q & tx_end;
		end
	end

	// Data leads data valid by a cycle at least; lines freed at once on attention
	assign drive = src_act & ((src_q == gpdi_pkg::sr_wait) | (src_q == gpdi_pkg::sr_dav));
	assign dio_oe = drive ? sh_byte_q : 8'h00;
	assign dio_o = 8'h00;
	assign dav_oe = src_act & (src_q == gpdi_pkg::sr_dav);
	assign dav_o = 1'b0;
	assign eoi_oe = drive & sh_eoi_q;
	assign eoi_o = 1'b0;
	assign srq_oe = svc_req;
	assign srq_o = 1'b0;

	// Status
	assign remote = remote_q;
	assign listen_act = listen_q;
	assign talk_act = talk_q;
	assign spoll_act = spoll_q;
	assign dev_clear = clear_q;
	assign trigger = trig_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_acc_take_seq: assert property (@(posedge mclk) disable iff (!rst_n)
		(take_now && !ifc_t) |=> (acc_q == gpdi_pkg::ac_take && (nrfd_oe || !acc_act)) ##1 !ndac_oe)
		else $error("acceptor did not hold not-ready then free not-accepted");
	a_src_wait_cond: assert property (@(posedge mclk) disable iff (!rst_n)
		($rose(dav_oe) && $past(src_q) == gpdi_pkg::sr_wait) |-> $past(!nrfd_t && ndac_t))
		else $error("data valid asserted before acceptors were ready");
	a_dav_release: assert property (@(posedge mclk) disable iff (!rst_n)
		(dav_oe && !ndac_t && !ifc_t) |=> !dav_oe ##1 (src_q == gpdi_pkg::sr_idle))
		else $error("data valid not released after acceptance");
	a_src_not_acc: assert property (@(posedge mclk) disable iff (!rst_n)
		dav_oe |-> (!nrfd_oe && !ndac_oe && dio_oe == sh_byte_q))
		else $error("source drove acceptor lines or lost its byte");
	a_atn_settle: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(atn_t) |-> ##[0:ATN_CYC] ndac_oe)
		else $error("not-accepted not held soon after attention");
	a_unl_drop: assert property (@(posedge mclk) disable iff (!rst_n)
		is_unl |=> !listen_q)
		else $error("listener kept role after unlisten");
	a_unt_drop: assert property (@(posedge mclk) disable iff (!rst_n)
		is_unt |=> !talk_q)
		else $error("talker kept role after untalk");
	a_ifc_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		ifc_t |=> (!listen_q && !talk_q && !dav_oe))
		else $error("interface clear left a role active");
	a_mla_listen: assert property (@(posedge mclk) disable iff (!rst_n)
		(is_mla && !ifc_t) |=> (listen_q && !talk_q))
		else $error("own listen address not taken");
	a_ren_local: assert property (@(posedge mclk) disable iff (!rst_n)
		!ren_t |=> (!remote && !front_lockout))
		else $error("remote kept with remote enable false");

endmodule : gpdi_core

// ===== gpdi_ctl_model.sv
// Bus controller model: sends addresses, commands and data, accepts talker bytes.
// Assumes the bench resolves every open-drain line with a pull-up.
module gpdi_ctl_model (
	// Clock
	input wire logic mclk,
	// Resolved bus lines
	input wire logic [7:0] dio_n,
	input wire logic dav_n,
	input wire logic nrfd_n,
	input wire logic ndac_n,
	input wire logic eoi_n,
	// Own drivers, high pulls the line low
	output logic [7:0] dio_e,
	output logic atn_e,
	output logic dav_e,
	output logic eoi_e,
	output logic ifc_e,
	output logic ren_e,
	output logic nrfd_e,
	output logic ndac_e
);
	timeunit 1ns;
	timeprecision 1ps;
	// All lines released at start
	initial begin
		{dio_e, atn_e, dav_e, eoi_e, ifc_e, ren_e, nrfd_e, ndac_e} = '0;
	end
	////////////////////////////////////////////////////////////////
	// Line conditions the handshake waits on
	function automatic bit cond(input int k);
		case (k)
			0: return nrfd_n === 1'b1 && ndac_n === 1'b0;
			1: return ndac_n === 1'b1;
			2: return dav_n === 1'b0;
			default: return dav_n === 1'b1;
		endcase
	endfunction : cond
	// Bounded wait, a stuck device clears ok instead of hanging
	task automatic wait_c(input int k, inout bit ok);
		int n;
		n = 0;
		while (!cond(k) && n < 600) begin
			@(posedge mclk);
			n++;
		end
		if (!cond(k)) ok = 0;
	endtask : wait_c
	// Uniline commands, only this side asserts them
	task automatic uni(input bit ren, input bit ifc);
		@(posedge mclk);
		ren_e <= ren;
		ifc_e <= ifc;
	endtask : uni
	// Source one byte; settle after attention before looking at acceptors
	task automatic send(input bit atn, input logic [7:0] b, input bit eoi, output bit ok);
		ok = 1;
		@(posedge mclk);
		atn_e <= atn;
		dio_e <= b;
		eoi_e <= eoi;
		repeat (30) @(posedge mclk);
		wait_c(0, ok);
		dav_e <= 1'b1;
		@(posedge mclk);
		wait_c(1, ok);
		dav_e <= 1'b0;
		dio_e <= 8'h00;
		eoi_e <= 1'b0;
	endtask : send
	// Accept one byte from the device, optionally slow on both steps
	task automatic recv(input int slow, output logic [7:0] b, output logic eoi, output bit ok);
		ok = 1;
		@(posedge mclk);
		atn_e <= 1'b0;
		nrfd_e <= 1'b1;
		ndac_e <= 1'b1;
		// At least one edge between hold and release, even when not slow
		repeat (slow + 1) @(posedge mclk);
		nrfd_e <= 1'b0;
		wait_c(2, ok);
		b = ~dio_n;
		eoi = ~eoi_n;
		nrfd_e <= 1'b1;
		repeat (slow) @(posedge mclk);
		ndac_e <= 1'b0;
		wait_c(3, ok);
		ndac_e <= 1'b0;
		nrfd_e <= 1'b0;
	endtask : recv
endmodule : gpdi_ctl_model

// ===== testbench.sv
// Bench for the GPIB device interface against a controller model.
// Assumes pull-ups on every bus line; my address is 16h.
`include "gpdi_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rst_n = 0, rx_ready = 0, tx_valid = 0, tx_end = 0, svc_req = 0;
	logic lock_cfg = 0, local_key = 0;
	logic [7:0] tx_data = 8'h00, status_byte = 8'h05, dio_o, dio_oe, c_dio, rx_data, b;
	logic dav_o, dav_oe, nrfd_o, nrfd_oe, ndac_o, ndac_oe, eoi_o, eoi_oe, srq_o, srq_oe, e;
	logic c_atn, c_dav, c_eoi, c_ifc, c_ren, c_nrfd, c_ndac, rx_valid, rx_end, tx_ready;
	logic remote, front_lockout, listen_act, talk_act, spoll_act, dev_clear, trigger;
	wire logic [7:0] dio_n = ~(c_dio | dio_oe);
	wire logic dav_n = ~(c_dav | dav_oe);
	wire logic nrfd_n = ~(c_nrfd | nrfd_oe);
	wire logic ndac_n = ~(c_ndac | ndac_oe);
	wire logic eoi_n = ~(c_eoi | eoi_oe);
	int err_total = 0, total_checks = 0, n_clr = 0, n_trg = 0;
	bit ok;
	localparam logic [7:0] LAG = 8'h36, TAG = 8'h56;
	always #2 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	gpdi_core uut (.mclk(mclk), .rst_n(rst_n), .dio_n_i(dio_n), .atn_n_i(~c_atn), .ifc_n_i(~c_ifc),
		.ren_n_i(~c_ren), .dav_n_i(dav_n), .nrfd_n_i(nrfd_n), .ndac_n_i(ndac_n), .eoi_n_i(eoi_n),
		.dio_o(dio_o), .dio_oe(dio_oe), .dav_o(dav_o), .dav_oe(dav_oe), .nrfd_o(nrfd_o),
		.nrfd_oe(nrfd_oe), .ndac_o(ndac_o), .ndac_oe(ndac_oe), .eoi_o(eoi_o), .eoi_oe(eoi_oe),
		.srq_o(srq_o), .srq_oe(srq_oe), .my_addr(5'h16), .lock_cfg(lock_cfg), .local_key(local_key),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_end(rx_end),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_end(tx_end),
		.svc_req(svc_req), .status_byte(status_byte), .remote(remote), .front_lockout(front_lockout),
		.listen_act(listen_act), .talk_act(talk_act), .spoll_act(spoll_act), .dev_clear(dev_clear),
		.trigger(trigger));
	gpdi_ctl_model ctl (.mclk(mclk), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n), .ndac_n(ndac_n),
		.eoi_n(eoi_n), .dio_e(c_dio), .atn_e(c_atn), .dav_e(c_dav), .eoi_e(c_eoi), .ifc_e(c_ifc),
		.ren_e(c_ren), .nrfd_e(c_nrfd), .ndac_e(c_ndac));
	// Pulses last one cycle, so count them where they stand
	always @(posedge mclk) begin
		if (dev_clear === 1'b1) n_clr++;
		if (trigger === 1'b1) n_trg++;
	end
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp, input string m);
		chk({7'h00, got}, {7'h00, exp}, m);
	endtask : chkb
	// A spent bound ends the run as a failure
	task automatic live(input bit k);
		if (!k) begin
			chkb(1'b0, 1'b1, "handshake timeout");
			print_verdict();
		end
	endtask : live
	task automatic cmd(input bit atn, input logic [7:0] v, input bit en);
		ctl.send(atn, v, en, ok);
		live(ok);
		repeat (4) @(posedge mclk);
	endtask : cmd
	task automatic pop(output logic [7:0] d, output logic en);
		int n;
		// Let the previous release pass an edge before asking again
		@(posedge mclk);
		rx_ready <= 1'b1;
		for (n = 0; n < 600; n++) begin
			@(posedge mclk);
			if (rx_valid === 1'b1) break;
		end
		live(rx_valid === 1'b1);
		d = rx_data;
		en = rx_end;
		rx_ready <= 1'b0;
	endtask : pop
	task automatic push(input logic [7:0] d, input logic en);
		int n;
		@(posedge mclk);
		tx_valid <= 1'b1;
		tx_data <= d;
		tx_end <= en;
		for (n = 0; n < 600; n++) begin
			@(posedge mclk);
			if (tx_ready === 1'b1) break;
		end
		live(tx_ready === 1'b1);
		tx_valid <= 1'b0;
	endtask : push
	////////////////////////////////////////////////////////////////
	// Listen, then three data bytes into a stalled receiver
	task automatic sc_listen;
		cmd(1, {1'b0, `GPDI_CMD_UNL}, 0);
		cmd(1, LAG, 0);
		chkb(listen_act, 1'b1, "listen");
		fork
			begin
				cmd(0, 8'h2a, 0);
				cmd(0, 8'h52, 0);
				cmd(0, 8'h53, 1);
			end
			begin
				repeat (220) @(posedge mclk);
				chkb(rx_valid, 1'b1, "held word");
				chkb(nrfd_oe, 1'b1, "stall");
				pop(b, e);
				chk(b, 8'h2a, "rx0");
				pop(b, e);
				chk(b, 8'h52, "rx1");
				pop(b, e);
				chk({b[6:0], e}, {7'h53, 1'b1}, "rx2 end");
			end
		join
	endtask : sc_listen
	// Remote, lockout, local, clears and trigger
	task automatic sc_cmds;
		ctl.uni(1, 0);
		cmd(1, LAG, 0);
		chkb(remote, 1'b1, "remote");
		lock_cfg <= 1'b1;
		local_key <= 1'b1;
		repeat (2) @(posedge mclk);
		chkb(remote, 1'b1, "key locked");
		lock_cfg <= 1'b0;
		repeat (2) @(posedge mclk);
		chkb(remote, 1'b0, "key local");
		local_key <= 1'b0;
		cmd(1, LAG, 0);
		chkb(remote, 1'b1, "remote again");
		cmd(1, {1'b0, `GPDI_CMD_LLO}, 0);
		chkb(front_lockout, 1'b1, "lockout");
		cmd(1, {1'b0, `GPDI_CMD_GTL}, 0);
		chkb(remote, 1'b0, "local");
		cmd(1, {1'b0, `GPDI_CMD_DCL}, 0);
		cmd(1, {1'b0, `GPDI_CMD_SDC}, 0);
		cmd(1, {1'b0, `GPDI_CMD_GET}, 0);
		chk(8'(n_clr), 8'h02, "clears");
		cmd(1, {1'b0, `GPDI_CMD_UNL}, 0);
		chkb(listen_act, 1'b0, "unlisten");
		cmd(1, {1'b0, `GPDI_CMD_SDC}, 0);
		cmd(1, {1'b0, `GPDI_CMD_GET}, 0);
		chk(8'(n_clr), 8'h02, "sdc unaddressed");
		chk(8'(n_trg), 8'h01, "trigger");
		ctl.uni(0, 0);
	endtask : sc_cmds
	// Talk two bytes, the second to a slow acceptor, then serial poll
	task automatic sc_talk;
		logic [7:0] b1;
		logic e1;
		cmd(1, TAG, 0);
		chkb(talk_act, 1'b1, "talk");
		fork
			begin
				push(8'h81, 0);
				push(8'h3c, 1);
			end
			begin
				ctl.recv(0, b, e, ok);
				live(ok);
				ctl.recv(20, b1, e1, ok);
				live(ok);
			end
		join
		chk({b[6:0], e}, {7'h01, 1'b0}, "tx0");
		chkb(b[7], 1'b1, "tx0 msb");
		chk({b1[6:0], e1}, {7'h3c, 1'b1}, "tx1 end");
		svc_req <= 1'b1;
		cmd(1, {1'b0, `GPDI_CMD_SPE}, 0);
		chkb(spoll_act, 1'b1, "poll on");
		chkb(srq_oe, 1'b1, "srq");
		ctl.recv(3, b, e, ok);
		live(ok);
		chk(b, 8'h45, "poll byte");
		cmd(1, {1'b0, `GPDI_CMD_SPD}, 0);
		chkb(spoll_act, 1'b0, "poll off");
		cmd(1, {1'b0, `GPDI_CMD_UNT}, 0);
		chkb(talk_act, 1'b0, "untalk");
		svc_req <= 1'b0;
	endtask : sc_talk
	// Interface clear drops both roles
	task automatic sc_ifc;
		// Roles exclude each other, so each is cleared on its own
		cmd(1, TAG, 0);
		ctl.uni(0, 1);
		repeat (8) @(posedge mclk);
		chkb(talk_act, 1'b0, "ifc talk");
		ctl.uni(0, 0);
		cmd(1, LAG, 0);
		ctl.uni(0, 1);
		repeat (8) @(posedge mclk);
		chkb(listen_act, 1'b0, "ifc listen");
		ctl.uni(0, 0);
	endtask : sc_ifc
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge mclk);
		chk(dio_oe, 8'h00, "reset dio");
		chk({4'h0, dav_oe, nrfd_oe, ndac_oe, listen_act}, 8'h00, "reset lines");
		chk({2'b00, dav_o, nrfd_o, ndac_o, eoi_o, srq_o, |dio_o}, 8'h00, "drive low only");
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		sc_listen();
		sc_cmds();
		sc_talk();
		sc_ifc();
		print_verdict();
	end
endmodule : testbench
